/* tcoc_pkg.sv */
// Package of constants and types for the touch output control block
package tcoc_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int HOLD_STEP_MS = 20;
   localparam int HOLD_STEP_CYC = (CLK_HZ / 1000) * HOLD_STEP_MS;
   localparam int BUZ_STEP_MS = 100;
   localparam int BUZ_STEP_CYC = (CLK_HZ / 1000) * BUZ_STEP_MS;
   localparam int FAULT_PULSE_MS = 50;
   localparam int FAULT_PULSE_CYC = (CLK_HZ / 1000) * FAULT_PULSE_MS;
   localparam int HI_PULSE_US = 100;
   localparam int HI_PULSE_CYC = (CLK_HZ / 1000000) * HI_PULSE_US;
   localparam int REFRESH_MS = 10;
   localparam int REFRESH_CYC = (CLK_HZ / 1000) * REFRESH_MS;
   localparam int HOLD_MAX_STEPS = 100;
   localparam int HOLD_W = 7;
   localparam int BUZ_W = 7;
   localparam int DUTY_W = 8;
   localparam int FREQ_W = 16;
   localparam logic [HOLD_W-1:0] HOLD_MAX = 7'h64;
   localparam logic [BUZ_W-1:0] BUZ_MIN = 7'h01;
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
   typedef enum logic {MODE_OPEN_DRAIN, MODE_PUSH_PULL} tcoc_drive_t;
   typedef enum logic [1:0] {BOOT_RUN, BOOT_PULSE, BOOT_DONE} tcoc_boot_t;
endpackage : tcoc_pkg

/* tcoc_tick.sv */
// Free-running divider giving a one-cycle enable every DIV cycles
`timescale 1ns/1ns
`default_nettype none
module tcoc_tick #(
   parameter int DIV = 400000,
   parameter int W = 24
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clr,
   output logic tick
);
   import tcoc_pkg::*;
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic tick_next;
   always_comb
   begin
      cnt_next = cnt_reg + W'(1);
      tick_next = 1'b0;
      if (clr)
      begin
         cnt_next = '0;
      end
      else if (cnt_reg == LAST)
      begin
         cnt_next = '0;
         tick_next = 1'b1;
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         tick <= tick_next;
      end
   end
endmodule : tcoc_tick
`default_nettype wire

/* tcoc_top.sv */
// Output stage: general outputs, sounder, host interrupt, sticky status
// Functional notes
// [RL1] Output follows sensor or host command
// [RL2] Polarity selectable per output
// [RL3] Deep sleep resets outputs to default
// [RL4] Open-drain or push-pull drive per output
// [RL5] PWM duty differs touched versus untouched
// [RL6] Host output: on/off use touched/untouched duty
// [RL7] Proximity event drives output, touch status-only
// [RL8] Hold output on after release, 20ms steps
// [RL9] Hold only sensor-driven, never with toggle
// [RL10] No hold after stuck-sensor auto reset
// [RL11] Toggle on each activation rising edge
// [RL12] Sounder tone for programmed 100ms units
// [RL13] Triggers during tone do not extend
// [RL14] Trigger while idle starts full tone
// [RL15] Sounder alternates while sounding, high idle
// [RL16] Host never enables sounder with noise algorithm
// [RL17] Low interrupt pulse on any status change
// [RL18] Interrupt pulses spaced a refresh; drive-low only
// [RL19] Sticky touch bit kept until host reads
// [RL20] Open-drain low: touched pulls low
// [RL21] Faulty sensor: 50ms pulse, sensor disabled
// [RL22] Shield/modulator fault: pulse all, disable all
// [RL23] Host output drives last written bit
`timescale 1ns/1ns
`default_nettype none
module tcoc_top #(
   parameter int N = 8,
   parameter int HOLD_CYC = tcoc_pkg::HOLD_STEP_CYC,
   parameter int BUZ_CYC = tcoc_pkg::BUZ_STEP_CYC,
   parameter int FAULT_CYC = tcoc_pkg::FAULT_PULSE_CYC,
   parameter int REFR_CYC = tcoc_pkg::REFRESH_CYC,
   parameter int HI_CYC = tcoc_pkg::HI_PULSE_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic deep_sleep,
   input wire logic [N-1:0] touch_sensor_input,
   input wire logic [N-1:0] prox_enable,
   input wire logic [N-1:0] prox_event,
   input wire logic [N-1:0] auto_reset_clear,
   input wire logic [N-1:0] host_ctrl_sel,
   input wire logic [N-1:0] host_out_level,
   input wire logic [N-1:0] active_high,
   input wire logic [N-1:0] push_pull,
   input wire logic [N-1:0] pwm_enable,
   input wire logic [tcoc_pkg::DUTY_W-1:0] duty_touch,
   input wire logic [tcoc_pkg::DUTY_W-1:0] duty_idle,
   input wire logic [N-1:0] hold_enable,
   input wire logic [tcoc_pkg::HOLD_W-1:0] hold_steps,
   input wire logic [N-1:0] toggle_enable,
   input wire logic [N-1:0] sounder_trigger_mask,
   input wire logic sounder_enable,
   input wire logic [tcoc_pkg::BUZ_W-1:0] sounder_units,
   input wire logic [tcoc_pkg::FREQ_W-1:0] sounder_half_period,
   input wire logic slider_change,
   input wire logic sticky_read,
   input wire logic boot_check_done,
   input wire logic [N-1:0] sensor_fault,
   input wire logic global_fault,
   output logic [N-1:0] general_output_pin_o,
   output logic [N-1:0] general_output_pin_oe_n,
   output logic sounder_output,
   output logic host_interrupt_line_o,
   output logic host_interrupt_line_oe_n,
   output logic [N-1:0] touch_status,
   output logic [N-1:0] sticky_touch_register,
   output logic [N-1:0] sensor_disabled,
   output logic boot_done
);
   import tcoc_pkg::*;
   localparam int CW = 24;

   // Three-stage synchronisers for the pin-side sensor inputs
   logic [N-1:0] ts1_reg, ts2_reg, ts3_reg, tsf_reg;
   logic [N-1:0] tsf_next;
   logic [N-1:0] act_reg, act_next;
   logic [N-1:0] tog_reg, tog_next;
   logic [N-1:0] sticky_touch_state;
   logic [N-1:0] sticky_next;
   logic [N-1:0] dis_next;
   logic [N-1:0] hold_act_reg, hold_act_next;
   logic [HOLD_W-1:0] hold_cnt_reg [N];
   logic [HOLD_W-1:0] hold_cnt_next [N];
   logic [N-1:0] src_on, out_on, drv_low;
   logic [N-1:0] pin_o_next, pin_oe_n_next;
   logic [DUTY_W-1:0] pwm_cnt_reg, pwm_cnt_next;
   logic hold_tick, buz_tick, buz_start;
   logic stat_chg;

   tcoc_tick #(.DIV(HOLD_CYC), .W(CW)) u_hold_tick (
      .core_clk(core_clk), .srst(srst), .clr(1'b0), .tick(hold_tick));
   // Divider restarts with each tone so its first unit is whole
   tcoc_tick #(.DIV(BUZ_CYC), .W(CW)) u_buz_tick (
      .core_clk(core_clk), .srst(srst), .clr(buz_start), .tick(buz_tick));

   // Boot self-test pulse sequencer
   tcoc_boot_t boot_reg, boot_next;
   logic [CW-1:0] fcnt_reg, fcnt_next;
   logic [N-1:0] fmask_reg, fmask_next;
   always_comb
   begin
      boot_next = boot_reg;
      fcnt_next = fcnt_reg;
      fmask_next = fmask_reg;
      dis_next = sensor_disabled;
      unique case (boot_reg)
         BOOT_RUN:
         begin
            if (boot_check_done)
            begin
               // [RL22] Global fault hits all
               fmask_next = global_fault ? '1 : sensor_fault;
               // [RL21] Faulty sensors disabled
               dis_next = global_fault ? '1 : sensor_fault;
               fcnt_next = '0;
               boot_next = (global_fault || (|sensor_fault)) ?
                  BOOT_PULSE : BOOT_DONE;
            end
         end
         BOOT_PULSE:
         begin
            // [RL21] Fault pulse length
            fcnt_next = fcnt_reg + CW'(1);
            if (fcnt_reg == CW'(FAULT_CYC - 1))
            begin
               fmask_next = '0;
               boot_next = BOOT_DONE;
            end
         end
         BOOT_DONE:
         begin
            boot_next = BOOT_DONE;
         end
      endcase
   end

   // Sensor activation, toggle, hold, sticky status
   always_comb
   begin
      tsf_next = tsf_reg;
      for (int i = 0; i < N; i++)
      begin
         if (ts2_reg[i] == ts3_reg[i])
         begin
            tsf_next[i] = ts3_reg[i];
         end
      end
      // [RL7] Proximity event is the activation
      act_next = ((prox_enable & prox_event) |
         (~prox_enable & tsf_reg)) & ~sensor_disabled;
      tog_next = tog_reg;
      hold_act_next = hold_act_reg;
      for (int i = 0; i < N; i++)
      begin
         hold_cnt_next[i] = hold_cnt_reg[i];
         // [RL11] Invert on rising activation
         if (toggle_enable[i] && act_next[i] && !act_reg[i])
         begin
            tog_next[i] = !tog_reg[i];
         end
         // [RL8] Start hold on release
         if (act_reg[i] && !act_next[i])
         begin
            // [RL9] [RL10] Hold gating
            hold_act_next[i] = hold_enable[i] && !toggle_enable[i] &&
               !host_ctrl_sel[i] && !auto_reset_clear[i] &&
               (hold_steps != '0);
            hold_cnt_next[i] = (hold_steps > HOLD_MAX) ? HOLD_MAX :
               hold_steps;
         end
         else if (act_next[i])
         begin
            hold_act_next[i] = 1'b0;
         end
         else if (hold_act_reg[i] && hold_tick)
         begin
            hold_cnt_next[i] = hold_cnt_reg[i] - HOLD_W'(1);
            if (hold_cnt_reg[i] <= HOLD_W'(1))
            begin
               hold_act_next[i] = 1'b0;
            end
         end
      end
      // [RL19] Set wins over host read clear
      sticky_next = (sticky_read ? '0 : sticky_touch_state) |
         (tsf_reg & ~sensor_disabled);
   end

   // Output drive
   always_comb
   begin
      pwm_cnt_next = pwm_cnt_reg + DUTY_W'(1);
      for (int i = 0; i < N; i++)
      begin
         // [RL1] [RL23] Source select
         src_on[i] = host_ctrl_sel[i] ? host_out_level[i] :
            (toggle_enable[i] ? tog_reg[i] : (act_reg[i] | hold_act_reg[i]));
         // [RL5] [RL6] Duty by on/off state
         if (pwm_enable[i])
         begin
            out_on[i] = src_on[i] ? (pwm_cnt_reg < duty_touch) :
               (pwm_cnt_reg < duty_idle);
         end
         else
         begin
            out_on[i] = src_on[i];
         end
         if (boot_reg == BOOT_PULSE && fmask_reg[i])
         begin
            out_on[i] = 1'b1;
         end
         // [RL2] Polarity
         drv_low[i] = active_high[i] ? !out_on[i] : out_on[i];
         // [RL4] [RL20] Drive mode
         if (push_pull[i])
         begin
            pin_o_next[i] = !drv_low[i];
            pin_oe_n_next[i] = 1'b0;
         end
         else
         begin
            pin_o_next[i] = 1'b0;
            pin_oe_n_next[i] = !drv_low[i];
         end
      end
   end

   // Sounder
   logic buz_on_reg, buz_on_next;
   logic [BUZ_W-1:0] buz_cnt_reg, buz_cnt_next;
   logic [FREQ_W-1:0] buz_div_reg, buz_div_next;
   logic buz_lvl_next;
   logic buz_trig;
   always_comb
   begin
      buz_trig = sounder_enable &&
         |(act_next & ~act_reg & sounder_trigger_mask);
      buz_start = buz_trig && !buz_on_reg;
      buz_on_next = buz_on_reg;
      buz_cnt_next = buz_cnt_reg;
      buz_div_next = buz_div_reg;
      buz_lvl_next = sounder_output;
      if (!buz_on_reg)
      begin
         buz_lvl_next = 1'b1;
         buz_div_next = '0;
         // [RL12] [RL14] Idle trigger starts full tone
         if (buz_trig)
         begin
            buz_on_next = 1'b1;
            buz_cnt_next = (sounder_units < BUZ_MIN) ? BUZ_MIN : sounder_units;
         end
      end
      else
      begin
         // [RL15] Alternate at set frequency
         if (buz_div_reg >= sounder_half_period)
         begin
            buz_div_next = '0;
            buz_lvl_next = !sounder_output;
         end
         else
         begin
            buz_div_next = buz_div_reg + FREQ_W'(1);
         end
         // [RL13] Triggers ignored while running
         if (buz_tick)
         begin
            buz_cnt_next = buz_cnt_reg - BUZ_W'(1);
            if (buz_cnt_reg <= BUZ_MIN)
            begin
               buz_on_next = 1'b0;
               buz_lvl_next = 1'b1;
            end
         end
      end
   end

   // Host interrupt
   logic hi_pend_reg, hi_pend_next;
   logic hi_busy_reg, hi_busy_next;
   logic hi_gap_reg, hi_gap_next;
   logic [CW-1:0] hi_cnt_reg, hi_cnt_next;
   logic hi_low_next;
   always_comb
   begin
      stat_chg = (act_next != act_reg) || slider_change;
      hi_pend_next = hi_pend_reg | stat_chg;
      hi_busy_next = hi_busy_reg;
      hi_gap_next = hi_gap_reg;
      hi_cnt_next = hi_cnt_reg;
      // [RL18] Full refresh from start to start
      if (hi_gap_reg && hi_cnt_reg == CW'(REFR_CYC - 1))
      begin
         hi_gap_next = 1'b0;
      end
      if (hi_busy_reg || hi_gap_reg)
      begin
         hi_cnt_next = hi_cnt_reg + CW'(1);
      end
      if (hi_busy_reg && hi_cnt_reg == CW'(HI_CYC - 1))
      begin
         hi_busy_next = 1'b0;
         hi_gap_next = 1'b1;
      end
      // [RL17] Start low pulse
      else if (!hi_busy_reg && hi_pend_reg && !hi_gap_reg)
      begin
         hi_busy_next = 1'b1;
         hi_pend_next = stat_chg;
         hi_cnt_next = '0;
      end
      hi_low_next = hi_busy_next;
   end

   always_ff @(posedge core_clk)
   begin
      // [RL3] Sleep restores defaults
      if (srst || deep_sleep)
      begin
         ts1_reg <= '0;
         ts2_reg <= '0;
         ts3_reg <= '0;
         tsf_reg <= '0;
         act_reg <= '0;
         tog_reg <= '0;
         hold_act_reg <= '0;
         for (int i = 0; i < N; i++)
         begin
            hold_cnt_reg[i] <= '0;
         end
         pwm_cnt_reg <= DUTY_ZERO;
         general_output_pin_o <= '0;
         general_output_pin_oe_n <= '1;
         buz_on_reg <= 1'b0;
         buz_cnt_reg <= '0;
         buz_div_reg <= '0;
         sounder_output <= 1'b1;
         hi_pend_reg <= 1'b0;
         hi_busy_reg <= 1'b0;
         hi_gap_reg <= 1'b0;
         hi_cnt_reg <= '0;
         host_interrupt_line_o <= 1'b0;
         host_interrupt_line_oe_n <= 1'b1;
         touch_status <= '0;
         sticky_touch_state <= '0;
         sticky_touch_register <= '0;
      end
      else
      begin
         ts1_reg <= touch_sensor_input;
         ts2_reg <= ts1_reg;
         ts3_reg <= ts2_reg;
         tsf_reg <= tsf_next;
         act_reg <= act_next;
         tog_reg <= tog_next;
         hold_act_reg <= hold_act_next;
         hold_cnt_reg <= hold_cnt_next;
         pwm_cnt_reg <= pwm_cnt_next;
         general_output_pin_o <= pin_o_next;
         general_output_pin_oe_n <= pin_oe_n_next;
         buz_on_reg <= buz_on_next;
         buz_cnt_reg <= buz_cnt_next;
         buz_div_reg <= buz_div_next;
         sounder_output <= buz_lvl_next;
         hi_pend_reg <= hi_pend_next;
         hi_busy_reg <= hi_busy_next;
         hi_gap_reg <= hi_gap_next;
         hi_cnt_reg <= hi_cnt_next;
         // [RL18] Drive low only
         host_interrupt_line_o <= 1'b0;
         host_interrupt_line_oe_n <= !hi_low_next;
         // [RL7] Touch status reported with or without proximity, masked for disabled sensors
         touch_status <= tsf_reg & ~sensor_disabled;
         sticky_touch_state <= sticky_next;
         sticky_touch_register <= sticky_next;
      end
   end

   // Boot state survives sleep; only reset reruns self-test
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         boot_reg <= BOOT_RUN;
         fcnt_reg <= '0;
         fmask_reg <= '0;
         sensor_disabled <= '0;
         boot_done <= 1'b0;
      end
      else
      begin
         boot_reg <= boot_next;
         fcnt_reg <= fcnt_next;
         fmask_reg <= fmask_next;
         sensor_disabled <= dis_next;
         boot_done <= (boot_next == BOOT_DONE);
      end
   end
endmodule : tcoc_top
`default_nettype wire

/* tcoc_props.sv */
// Concurrent checks on the touch output control ports
`timescale 1ns/1ns
`default_nettype none
module tcoc_props #(
   parameter int N = 8,
   parameter int HI_CYC = 3,
   parameter int REFR_CYC = 50
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic deep_sleep,
   input wire logic [N-1:0] host_ctrl_sel,
   input wire logic [N-1:0] host_out_level,
   input wire logic [N-1:0] active_high,
   input wire logic [N-1:0] push_pull,
   input wire logic [N-1:0] pwm_enable,
   input wire logic [tcoc_pkg::FREQ_W-1:0] sounder_half_period,
   input wire logic [N-1:0] sensor_fault,
   input wire logic global_fault,
   input wire logic [N-1:0] general_output_pin_o,
   input wire logic [N-1:0] general_output_pin_oe_n,
   input wire logic sounder_output,
   input wire logic host_interrupt_line_o,
   input wire logic host_interrupt_line_oe_n,
   input wire logic [N-1:0] touch_status,
   input wire logic [N-1:0] sticky_touch_register,
   input wire logic [N-1:0] sensor_disabled,
   input wire logic boot_done
);
   import tcoc_pkg::*;
   int low_cnt, gap_cnt, snd_low;
   logic irq_prev;
   // Deep sleep also restarts them, since it cuts pulses short
   always_ff @(posedge core_clk)
   begin
      if (srst || deep_sleep)
      begin
         low_cnt <= 0;
         snd_low <= 0;
         gap_cnt <= REFR_CYC;
         irq_prev <= 1'b1;
      end
      else
      begin
         low_cnt <= host_interrupt_line_oe_n ? 0 : low_cnt + 1;
         snd_low <= sounder_output ? 0 : snd_low + 1;
         irq_prev <= host_interrupt_line_oe_n;
         if (irq_prev && !host_interrupt_line_oe_n)
            gap_cnt <= 1;
         else if (gap_cnt < REFR_CYC)
            gap_cnt <= gap_cnt + 1;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   hi_width_a:
      assert property ($rose(host_interrupt_line_oe_n) && !$past(deep_sleep)
         |-> low_cnt == HI_CYC) else $error("interrupt pulse width wrong");
   hi_gap_a:
      assert property ($fell(host_interrupt_line_oe_n) |->
         gap_cnt >= REFR_CYC) else $error("interrupt pulses too close");
   hi_low_only_a:
      assert property (!host_interrupt_line_o)
      else $error("interrupt line driven high");
   sleep_default_a:
      assert property (deep_sleep |=> &general_output_pin_oe_n
         && sounder_output && host_interrupt_line_oe_n && touch_status == '0)
      else $error("outputs not default in deep sleep");
   sounder_run_a:
      assert property (!sounder_output |->
         snd_low <= int'(sounder_half_period))
      else $error("sounder low phase too long");
   sticky_set_a:
      assert property ((touch_status & ~$past(touch_status)) != '0 |->
         (touch_status & ~$past(touch_status) & ~sticky_touch_register) == '0)
      else $error("sticky bit missing after touch");
   boot_mask_a:
      assert property ($rose(boot_done) |-> sensor_disabled ==
         (global_fault ? {N{1'b1}} : sensor_fault))
      else $error("wrong sensors disabled at boot");
   host_drive_a:
      assert property ((host_ctrl_sel[1] && push_pull[1] && !pwm_enable[1]
         && boot_done && !deep_sleep && $stable(host_out_level[1])
         && $stable(active_high[1]))[*4] |-> !general_output_pin_oe_n[1]
         && general_output_pin_o[1] == (host_out_level[1] ~^ active_high[1]))
      else $error("host driven pin wrong");
endmodule : tcoc_props
`default_nettype wire

/* tcoc_host.sv */
// Host model: pulled-up interrupt line and sticky status reads
`timescale 1ns/1ns
`default_nettype none
module tcoc_host (
   input wire logic core_clk,
   input wire logic int_o,
   input wire logic int_oe_n,
   input wire logic read_en,
   output var logic sticky_read,
   output var int irq_count
);
   logic line_lvl;
   logic line_prev = 1'b1;
   // Released line floats high through the pull-up
   assign line_lvl = int_oe_n | int_o;
   initial
   begin
      sticky_read = 1'b0;
      irq_count = 0;
   end
   always @(negedge core_clk)
   begin
      sticky_read <= read_en && line_prev && !line_lvl;
      irq_count <= irq_count + int'(line_prev && !line_lvl);
      line_prev <= line_lvl;
   end
endmodule : tcoc_host
`default_nettype wire

/* touch_output_control_bench.sv */
// Self-checking bench for the touch output control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module touch_output_control_bench;
   import tcoc_pkg::*;
   logic core_clk, srst, deep_sleep, sounder_enable, slider_change;
   logic sticky_read, boot_check_done, global_fault, read_en;
   logic [7:0] touch_sensor_input, prox_enable, prox_event;
   logic [7:0] auto_reset_clear, host_ctrl_sel, host_out_level;
   logic [7:0] active_high, push_pull, pwm_enable, hold_enable;
   logic [7:0] toggle_enable, sounder_trigger_mask, sensor_fault;
   logic [7:0] general_output_pin_o, general_output_pin_oe_n;
   logic [7:0] touch_status, sticky_touch_register, sensor_disabled;
   logic [7:0] act, m, wire_lvl;
   logic [15:0] got_pins;
   logic [DUTY_W-1:0] duty_touch, duty_idle;
   logic [HOLD_W-1:0] hold_steps;
   logic [BUZ_W-1:0] sounder_units;
   logic [FREQ_W-1:0] sounder_half_period;
   logic sounder_output, host_interrupt_line_o;
   logic host_interrupt_line_oe_n, boot_done;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int irq_count, n, first, last;
   assign wire_lvl = general_output_pin_oe_n | general_output_pin_o;
   assign got_pins = {general_output_pin_oe_n, wire_lvl} & 16'hfafa;
   tcoc_top #(.HOLD_CYC(10), .BUZ_CYC(10), .FAULT_CYC(20),
      .REFR_CYC(50), .HI_CYC(3)) DUT (.*);
   tcoc_host HOST (.core_clk(core_clk), .int_o(host_interrupt_line_o),
      .int_oe_n(host_interrupt_line_oe_n), .read_en(read_en),
      .sticky_read(sticky_read), .irq_count(irq_count));
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic complete_run;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // Run is about 5050 cycles long
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 9000)
      begin
         bad_count++;
         complete_run;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc
   // Open drain releases the pin for a high level
   function automatic logic [15:0] exp_pins(input logic [7:0] a);
      logic [7:0] lvl;
      lvl = ~(active_high ^ a);
      return (deep_sleep ? 16'hffff : {~push_pull & lvl, lvl}) & 16'hfafa;
   endfunction : exp_pins
   task automatic boot(input logic [7:0] f, input logic g);
      srst = 1'b1;
      cyc(20);
      srst = 1'b0;
      `CHK({general_output_pin_oe_n, sounder_output, boot_done}, 10'h3fe);
      sensor_fault = f;
      global_fault = g;
      boot_check_done = 1'b1;
      cyc(1);
      boot_check_done = 1'b0;
      cyc(8);
      `CHK(wire_lvl, g ? 8'hff : f);
      cyc(40);
      `CHK({sensor_disabled, wire_lvl, boot_done}, {g ? 8'hff : f, 9'h1});
   endtask : boot
   initial
   begin
      void'($urandom(59));
      {deep_sleep, sounder_enable, slider_change, boot_check_done} = '0;
      {global_fault, read_en, srst} = '0;
      {touch_sensor_input, prox_enable, prox_event, auto_reset_clear} = '0;
      {host_ctrl_sel, host_out_level, pwm_enable, hold_enable} = '0;
      {toggle_enable, sounder_trigger_mask, sensor_fault} = '0;
      {active_high, push_pull} = 16'hffff;
      {duty_touch, duty_idle, hold_steps, sounder_units} = '0;
      sounder_half_period = '0;
      boot(8'h05, 1'b0);
      for (int i = 0; i < 40; i++)
      begin
         {touch_sensor_input, prox_event} = 16'($urandom);
         {prox_enable, host_ctrl_sel, host_out_level} = 24'($urandom);
         {active_high, push_pull} = 16'($urandom);
         deep_sleep = ($urandom % 6) == 0;
         cyc(12);
         act = host_ctrl_sel & host_out_level | ~host_ctrl_sel
            & (prox_enable & prox_event | ~prox_enable & touch_sensor_input);
         m = 8'hfa;
         `CHK(got_pins, exp_pins(act));
         `CHK(touch_status & m, deep_sleep ? 8'h0 : touch_sensor_input & m);
      end
      deep_sleep = 1'b0;
      {prox_enable, host_ctrl_sel, touch_sensor_input} = '0;
      {active_high, push_pull} = 16'hffff;
      {duty_touch, duty_idle} = 16'($urandom);
      pwm_enable = 8'h02;
      for (int k = 0; k < 4; k++)
      begin
         host_ctrl_sel[1] = k[1];
         host_out_level[1] = k[0];
         touch_sensor_input[1] = k[0] & !k[1];
         cyc(12);
         n = 0;
         repeat (1024)
         begin
            cyc(1);
            n += int'(general_output_pin_o[1]);
         end
         `CHK(n, 4 * (k[0] ? duty_touch : duty_idle));
      end
      {pwm_enable, host_ctrl_sel} = '0;
      {hold_enable, toggle_enable, hold_steps} = {8'h08, 8'h10, 7'h03};
      for (int k = 0; k < 2; k++)
      begin
         touch_sensor_input[4:3] = 2'b11;
         cyc(12);
         touch_sensor_input[4:3] = 2'b00;
         auto_reset_clear[3] = k[0];
         n = 0;
         while (general_output_pin_o[3] && n < 80)
         begin
            cyc(1);
            n++;
         end
         auto_reset_clear[3] = 1'b0;
         `CHK(k ? n < 10 : n > 22 && n < 40, 1'b1);
         `CHK(general_output_pin_o[4], !k[0]);
      end
      {sounder_enable, sounder_units} = {1'b1, 7'h02};
      sounder_half_period = 16'h1;
      sounder_trigger_mask = 8'h60;
      for (int k = 0; k < 2; k++)
      begin
         touch_sensor_input[6:5] = 2'b01;
         first = -1;
         for (int c = 0; c < 60; c++)
         begin
            cyc(1);
            if (c == 10)
               touch_sensor_input[6] = 1'b1;
            if (!sounder_output)
            begin
               last = c;
               if (first < 0)
                  first = c;
            end
         end
         `CHK(last - first > 14 && last - first < 20, 1'b1);
         touch_sensor_input[6:5] = 2'b00;
         cyc(12);
      end
      `CHK({touch_status[5], sticky_touch_register[5]}, 2'b01);
      read_en = 1'b1;
      slider_change = 1'b1;
      cyc(1);
      slider_change = 1'b0;
      cyc(80);
      `CHK({sticky_touch_register[5], irq_count > 0}, 2'b01);
      boot(8'h00, 1'b1);
      complete_run;
   end
endmodule : touch_output_control_bench
bind tcoc_top tcoc_props #(.N(N), .HI_CYC(HI_CYC), .REFR_CYC(REFR_CYC))
   PROPS (.*);
`default_nettype wire
